//--- verilog/rld_pkg.sv
// rld_pkg: constants and types for the register load datapath
package rld_pkg;

  // *****************************************************************
  // load kinds
  // *****************************************************************
  typedef enum logic [2:0] {
    RLD_LOAD_WORD      = 3'h0,
    RLD_ORD_BYTE       = 3'h1,
    RLD_ORD_HALF       = 3'h2,
    RLD_INT_BYTE       = 3'h3,
    RLD_INT_HALF       = 3'h4,
    RLD_LOAD_TWO_WORDS = 3'h5,
    RLD_LOAD_TRIPLE    = 3'h6,
    RLD_LOAD_QUAD      = 3'h7
  } rld_kind_e;

  // *****************************************************************
  // controller states
  // *****************************************************************
  typedef enum logic [1:0] {
    RLD_IDLE = 2'h0,
    RLD_REQ  = 2'h1,
    RLD_WAIT = 2'h2
  } rld_state_e;

  // *****************************************************************
  // fixed figures
  // *****************************************************************
  localparam logic [31:0] RLD_WORD_STEP = 32'h0000_0004;
  localparam logic [2:0] RLD_CNT_RST = 3'h0;
  localparam logic [31:0] RLD_DATA_RST = 32'h0000_0000;
  localparam logic [23:0] RLD_ONES_24 = 24'hFF_FFFF;
  localparam logic [15:0] RLD_ONES_16 = 16'hFFFF;

endpackage

//--- verilog/rld_extend.sv
// rld_extend: widens a fetched word to a full register value
`timescale 1ns/1ps

module rld_extend (
  // load kind
  input wire rld_pkg::rld_kind_e kind,
  // raw memory word
  input wire logic [31:0] raw,
  // widened result
  output logic [31:0] value
);

  always_comb begin
    case (kind)
      rld_pkg::RLD_ORD_BYTE: begin
        value = {24'h00_0000, raw[7:0]}; // [R1] [R2]
      end
      rld_pkg::RLD_INT_BYTE: begin
        value = {(raw[7] ? rld_pkg::RLD_ONES_24 : 24'h00_0000),
                 raw[7:0]}; // [R2] [R10]
      end
      rld_pkg::RLD_ORD_HALF: begin
        value = {16'h0000, raw[15:0]}; // [R16]
      end
      rld_pkg::RLD_INT_HALF: begin
        value = {(raw[15] ? rld_pkg::RLD_ONES_16 : 16'h0000),
                 raw[15:0]}; // [R11]
      end
      default: begin
        value = raw;
      end
    endcase
  end

endmodule

//--- verilog/rld_load_unit.sv
// rld_load_unit: sequences memory reads into the register file
`timescale 1ns/1ps

// How it works
// R1 - byte/half loads widen to 32 bits
// R2 - integer loads sign-extend, ordinal zero-extend
// R3 - word, long, triple, quad move 4/8/12/16 bytes
// R4 - dst names lowest register, words ascend
// R5 - caller supplies effective address of first byte
// R6 - issuer names even register for long loads
// R7 - issuer names multiple-of-four for triple/quad
// R8 - misaligned group results left undefined
// R9 - word load faults on address bits 1:0
// R10 - integer byte fills 31:8 from bit 7
// R11 - integer half fills 31:16 from bit 15
// R12 - half loads fault on address bit 0
// R13 - odd long destination raises invalid operand
// R14 - quad load faults on address bits 3:0
// R15 - multi-word reads step address by four
// R16 - ordinal half writes zeros to 31:16
module rld_load_unit #(
  parameter int REG_BITS = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command from the core
  input wire logic cmd_valid,
  input wire rld_pkg::rld_kind_e cmd_kind,
  input wire logic [31:0] cmd_addr,
  input wire logic [REG_BITS-1:0] cmd_dst,
  input wire logic unaligned_fault_en,
  output logic cmd_ready,
  // memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // register file write port
  output logic rf_we,
  output logic [REG_BITS-1:0] rf_waddr,
  output logic [31:0] rf_wdata,
  // completion and faults
  output logic done,
  output logic fault_unaligned,
  output logic fault_invalid_operand
);

  // *****************************************************************
  // state
  // *****************************************************************
  rld_pkg::rld_state_e state_q;
  rld_pkg::rld_kind_e kind_q;
  logic [31:0] addr_q;
  logic [REG_BITS-1:0] reg_q;
  logic [2:0] left_q;
  logic [31:0] ext_value;
  logic [2:0] words;
  logic misaligned;
  logic odd_long;
  logic take;
  logic word_ack;
  logic last_word;

  // *****************************************************************
  // command decode
  // *****************************************************************
  always_comb begin
    case (cmd_kind)
      rld_pkg::RLD_LOAD_TWO_WORDS: words = 3'h2; // [R3]
      rld_pkg::RLD_LOAD_TRIPLE: words = 3'h3; // [R3]
      rld_pkg::RLD_LOAD_QUAD: words = 3'h4; // [R3]
      default: words = 3'h1; // [R1] [R3]
    endcase
  end

  always_comb begin
    case (cmd_kind)
      rld_pkg::RLD_LOAD_WORD: misaligned = cmd_addr[1:0] != 2'h0; // [R9]
      rld_pkg::RLD_ORD_HALF,
      rld_pkg::RLD_INT_HALF: misaligned = cmd_addr[0]; // [R12]
      rld_pkg::RLD_LOAD_TWO_WORDS: misaligned = cmd_addr[2:0] != 3'h0;
      rld_pkg::RLD_LOAD_QUAD: misaligned = cmd_addr[3:0] != 4'h0; // [R14]
      default: misaligned = 1'b0;
    endcase
  end

  // group alignment of triple/quad is the issuer's duty; unchecked
  assign odd_long = (cmd_kind == rld_pkg::RLD_LOAD_TWO_WORDS)
                    && cmd_dst[0]; // [R13] [R6] [R7] [R8]

  rld_extend u_extend (
    .kind(kind_q),
    .raw(mem_rdata),
    .value(ext_value)
  );

  // *****************************************************************
  // sequencer
  // *****************************************************************
  // an odd long destination is refused here, so nothing is fetched
  assign take = (state_q == rld_pkg::RLD_IDLE) && cmd_valid
                && !odd_long; // [R13]
  assign word_ack = (state_q == rld_pkg::RLD_WAIT) && mem_ack;
  assign last_word = left_q == 3'h1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rld_pkg::RLD_IDLE;
    end else begin
      case (state_q)
        rld_pkg::RLD_IDLE: begin
          if (take) begin
            state_q <= rld_pkg::RLD_REQ;
          end
        end
        rld_pkg::RLD_REQ: begin
          state_q <= rld_pkg::RLD_WAIT;
        end
        rld_pkg::RLD_WAIT: begin
          if (mem_ack && last_word) begin
            state_q <= rld_pkg::RLD_IDLE;
          end else if (mem_ack) begin
            state_q <= rld_pkg::RLD_REQ;
          end
        end
        default: begin
          state_q <= rld_pkg::RLD_IDLE;
        end
      endcase
    end
  end

  // load kind is held for the widener until the last word lands
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= rld_pkg::RLD_LOAD_WORD;
    end else if (take) begin
      kind_q <= cmd_kind;
    end
  end

  // word address steps by four after each answered read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= rld_pkg::RLD_DATA_RST;
    end else if (take) begin
      addr_q <= cmd_addr; // [R5]
    end else if (word_ack) begin
      addr_q <= addr_q + rld_pkg::RLD_WORD_STEP; // [R15]
    end
  end

  // destination register climbs from the named base
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_q <= '0;
    end else if (take) begin
      reg_q <= cmd_dst; // [R4]
    end else if (word_ack) begin
      reg_q <= reg_q + REG_BITS'(1); // [R4]
    end
  end

  // words still to fetch for the current load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= rld_pkg::RLD_CNT_RST;
    end else if (take) begin
      left_q <= words; // [R3]
    end else if (word_ack) begin
      left_q <= left_q - 3'h1;
    end
  end

  // *****************************************************************
  // memory and register file ports
  // *****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_addr <= rld_pkg::RLD_DATA_RST;
    end else begin
      mem_req <= (state_q == rld_pkg::RLD_REQ)
                 || (state_q == rld_pkg::RLD_WAIT && !mem_ack);
      if (state_q == rld_pkg::RLD_REQ) begin
        mem_addr <= addr_q; // [R15]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rf_we <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= rld_pkg::RLD_DATA_RST;
    end else begin
      rf_we <= (state_q == rld_pkg::RLD_WAIT) && mem_ack;
      if (state_q == rld_pkg::RLD_WAIT && mem_ack) begin
        rf_waddr <= reg_q; // [R4]
        rf_wdata <= ext_value; // [R1] [R2]
      end
    end
  end

  // *****************************************************************
  // completion and faults
  // *****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
      done <= 1'b0;
      fault_unaligned <= 1'b0;
      fault_invalid_operand <= 1'b0;
    end else begin
      cmd_ready <= (state_q == rld_pkg::RLD_IDLE) && !cmd_valid;
      done <= (state_q == rld_pkg::RLD_WAIT) && mem_ack
              && (left_q == 3'h1);
      fault_invalid_operand <= (state_q == rld_pkg::RLD_IDLE)
                               && cmd_valid && odd_long; // [R13]
      fault_unaligned <= (state_q == rld_pkg::RLD_IDLE) && cmd_valid
                         && !odd_long && misaligned
                         && unaligned_fault_en; // [R9] [R12] [R14]
    end
  end

endmodule

//--- testbench/rld_load_unit_chk.sv
// rld_load_unit_chk: port-level checks of the load unit
`timescale 1ns/1ps
module rld_load_unit_chk #(
  parameter int REG_BITS = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command
  input wire logic cmd_valid,
  input wire rld_pkg::rld_kind_e cmd_kind,
  input wire logic [31:0] cmd_addr,
  input wire logic [REG_BITS-1:0] cmd_dst,
  input wire logic unaligned_fault_en,
  input wire logic cmd_ready,
  // memory and register file
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic rf_we,
  // status
  input wire logic done,
  input wire logic fault_unaligned,
  input wire logic fault_invalid_operand
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = cmd_valid && cmd_ready;
  wire k2 = cmd_kind == rld_pkg::RLD_LOAD_TWO_WORDS;
  wire odd2 = take && k2 && cmd_dst[0];
  wire chk_u = take && unaligned_fault_en;
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr)) else $error("request dropped early");
  ack_write_a: assert property (mem_req && mem_ack |=> rf_we)
    else $error("no write after ack");
  done_we_a: assert property (done |-> rf_we)
    else $error("done without write");
  odd_fault_a: assert property (odd2 |=> fault_invalid_operand)
    else $error("odd long load not refused");
  odd_quiet_a: assert property (odd2 |=> !mem_req [*4])
    else $error("odd long load reached memory");
  word_unal_a: assert property (chk_u && cmd_addr[1:0] != 2'h0 &&
    cmd_kind == rld_pkg::RLD_LOAD_WORD |=> fault_unaligned)
    else $error("word unaligned not flagged");
  quad_unal_a: assert property (chk_u && cmd_addr[3:0] != 4'h0 &&
    cmd_kind == rld_pkg::RLD_LOAD_QUAD |=> fault_unaligned)
    else $error("quad unaligned not flagged");
  half_unal_a: assert property (chk_u && cmd_addr[0] &&
    (cmd_kind == rld_pkg::RLD_ORD_HALF || cmd_kind == rld_pkg::RLD_INT_HALF)
    |=> fault_unaligned) else $error("half unaligned not flagged");
  no_unal_a: assert property (take && !unaligned_fault_en
    |=> !fault_unaligned) else $error("fault while disabled");
  cover property (take && cmd_kind == rld_pkg::RLD_LOAD_QUAD);
  cover property (fault_invalid_operand);
  cover property (done);
endmodule
bind rld_load_unit rld_load_unit_chk #(.REG_BITS(REG_BITS)) u_chk (
  .clk_sys, .rst_n, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_dst,
  .unaligned_fault_en, .cmd_ready, .mem_req, .mem_addr, .mem_ack, .rf_we,
  .done, .fault_unaligned, .fault_invalid_operand);

//--- testbench/rld_mem_model.sv
// rld_mem_model: memory with adjustable answer delay
`timescale 1ns/1ps
module rld_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // read port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt_q;
  // data is address xor a fixed pattern; garbage toggles between answers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt_q <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        cnt_q <= (cnt_q >= lat) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q >= lat) begin
          mem_ack <= 1'b1;
          mem_rdata <= mem_addr ^ 32'h5A5A_C3C3;
        end
      end
    end
  end
endmodule

//--- testbench/rld_load_unit_tb.sv
// rld_load_unit_tb: directed checks of the load unit
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_fail++; $display("[ERR] %0t mismatch", $time); end end
module rld_load_unit_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, en = 1'b0;
  rld_pkg::rld_kind_e cmd_kind = rld_pkg::RLD_LOAD_WORD;
  logic [31:0] cmd_addr = 32'h0000_0000, mem_addr, mem_rdata, rf_wdata;
  logic [4:0] cmd_dst = 5'h00, rf_waddr;
  logic [3:0] lat = 4'h0;
  logic cmd_ready, mem_req, mem_ack, rf_we, done, fu_w, fi_w, fu, fi, dn;
  logic [4:0] wa[8];
  logic [31:0] wd[8], w, e;
  int n_fail = 0, samples_checked = 0, nw;
  always #5 clk_sys = ~clk_sys;
  rld_load_unit u_dut (.clk_sys, .rst_n, .cmd_valid, .cmd_kind, .cmd_addr,
    .cmd_dst, .unaligned_fault_en(en), .cmd_ready, .mem_req, .mem_addr,
    .mem_ack, .mem_rdata, .rf_we, .rf_waddr, .rf_wdata, .done,
    .fault_unaligned(fu_w), .fault_invalid_operand(fi_w));
  rld_mem_model u_mem (.clk_sys, .rst_n, .mem_req, .mem_addr, .lat,
    .mem_ack, .mem_rdata);
  always @(posedge clk_sys) begin
    if (rf_we === 1'b1 && nw < 8) begin
      wa[nw] = rf_waddr;
      wd[nw] = rf_wdata;
      nw++;
    end
    if (fu_w === 1'b1) fu = 1'b1;
    if (fi_w === 1'b1) fi = 1'b1;
    if (done === 1'b1) dn = 1'b1;
  end
  task results;
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task issue(input int k, input logic [31:0] a, input logic [4:0] d);
    int i;
    repeat (2) @(negedge clk_sys);
    {nw, fu, fi, dn} = '0;
    cmd_kind = rld_pkg::rld_kind_e'(k);
    {cmd_addr, cmd_dst, cmd_valid} = {a, d, 1'b1};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 80 && !dn && !fi; i++) @(negedge clk_sys);
    if (i == 80) begin
      n_fail++;
      results();
    end
  endtask
  task t_ext;
    for (int k = 1; k < 5; k++) begin
      for (int j = 0; j < 2; j++) begin
        w = (j != 0) ? 32'h0000_8080 : 32'h0000_0100;
        issue(k, w, 5'h04);
        w = w ^ 32'h5A5A_C3C3;
        e = (k == 1) ? {24'h00_0000, w[7:0]}
          : (k == 3) ? {{24{w[7]}}, w[7:0]}
          : (k == 2) ? {16'h0000, w[15:0]} : {{16{w[15]}}, w[15:0]};
        `CHK(wd[0], e)
      end
    end
  endtask
  task t_multi;
    en = 1'b1;
    for (int n = 1; n < 5; n++) begin
      lat = 4'(2 * n - 2);
      issue((n == 1) ? 0 : n + 3, 32'h0000_0200, 5'h08);
      `CHK(nw, n)
      `CHK(dn, 1'b1)
      `CHK(fu, 1'b0)
      for (int j = 0; j < n; j++) begin
        `CHK(wa[j], 5'(8 + j))
        `CHK(wd[j], (32'h0000_0200 + 32'(4 * j)) ^ 32'h5A5A_C3C3)
      end
    end
  endtask
  task t_fault;
    issue(0, 32'h0000_0202, 5'h04);
    `CHK(fu, 1'b1)
    issue(2, 32'h0000_0101, 5'h04);
    `CHK(fu, 1'b1)
    issue(7, 32'h0000_0208, 5'h04);
    `CHK(fu, 1'b1)
    issue(4, 32'h0000_0103, 5'h04);
    `CHK(fu, 1'b1)
    issue(5, 32'h0000_0204, 5'h08);
    `CHK(fu, 1'b1)
    `CHK(nw, 2)
    issue(3, 32'h0000_0101, 5'h04);
    `CHK(fu, 1'b0)
    en = 1'b0;
    issue(0, 32'h0000_0202, 5'h04);
    `CHK(fu, 1'b0)
    issue(5, 32'h0000_0200, 5'h09);
    repeat (4) @(negedge clk_sys);
    `CHK(fi, 1'b1)
    `CHK(nw, 0)
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    t_ext();
    t_multi();
    t_fault();
    results();
  end
endmodule
